// [hw/dac_calibration_adjust.sv]
// Purpose: offset and gain calibration path plus measurement status report
// Assumes: serial interface already decoded into single-cycle register strobes
// Notes: output code is updated two edges after a data register write
//        output saturates at full code as well as at zero scale
//        status and unmapped writes leave the calibration alone
//
// Function
// - Offset calibration register is writable and readable by the host.
// - Gain calibration register is writable and readable by the host.
// - New offset only applies after a later data register write.
// - New gain only applies after a later data register write.
// - Offset register is one 16-bit field, bits 15 to 0.
// - Gain register is one 16-bit field, bits 15 to 0.
// - Offset correction is value minus 32768; resets to 32768.
// - Gain correction is a factor of value over 2^16; resets to 65535.
// - Measurement reported as 8-bit unsigned code in status word.
// - Loop supply code means volts equal 2.5/256 times code.
// - Temperature code means degrees equal 312 minus 1.559 times code.
// - Output equals data times gain over 2^16 plus offset minus 32768.
// - Negative offset never drives output below zero scale; clamp.
`timescale 1ns/1ps
`default_nettype none

module dac_calibration_adjust
   import cal_adjust_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [WORD_W-1:0] reg_wdata,
   output logic [WORD_W-1:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic [MEAS_W-1:0] meas_code,
   input wire logic meas_is_temp_in,
   output logic [MEAS_W-1:0] meas_status,
   output logic meas_is_temp,
   output logic [WORD_W-1:0] dac_code
);

   logic [WORD_W-1:0] offset_pend;
   logic [WORD_W-1:0] gain_pend;
   logic [WORD_W-1:0] offset_act;
   logic [WORD_W-1:0] gain_act;
   logic [WORD_W-1:0] data_reg;

   // register index match, shared by write decode, read mux and checks
   function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] idx);
      return a == idx;
   endfunction

   // address decode
   wire wr_data = reg_write && addr_is(reg_addr, ADDR_DATA);
   wire wr_offset = reg_write && addr_is(reg_addr, ADDR_OFFSET);
   wire wr_gain = reg_write && addr_is(reg_addr, ADDR_GAIN);

   // transfer function: data * gain / 2^16 + offset - 32768
   wire [2*WORD_W-1:0] product = {{WORD_W{1'b0}}, data_reg} * {{WORD_W{1'b0}}, gain_act};
   wire [WORD_W+1:0] scaled = {2'b00, product[2*WORD_W-1:WORD_W]};
   wire [WORD_W+1:0] sum = scaled + {2'b00, offset_act} - OFFSET_ZERO;
   wire sum_neg = sum[WORD_W+1];
   wire sum_over = !sum_neg && sum[WORD_W];
   wire [WORD_W-1:0] next_code = sum_neg ? '0 : (sum_over ? CODE_MAX : sum[WORD_W-1:0]);

   // read mux; status word carries the measurement code
   wire [WORD_W-1:0] status_word = {{(WORD_W-STAT_TEMP_BIT-1){1'b0}}, meas_is_temp, meas_status};
   wire [WORD_W-1:0] next_rdata = addr_is(reg_addr, ADDR_DATA) ? data_reg :
                                  addr_is(reg_addr, ADDR_OFFSET) ? offset_pend :
                                  addr_is(reg_addr, ADDR_GAIN) ? gain_pend :
                                  addr_is(reg_addr, ADDR_STATUS) ? status_word : '0;

   // pending calibration values, full 16-bit fields
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         offset_pend <= OFFSET_RESET;
         gain_pend <= GAIN_RESET;
      end else begin
         if (wr_offset) offset_pend <= reg_wdata;
         if (wr_gain) gain_pend <= reg_wdata;
      end
   end

   // data write latches data and applies pending calibration
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         data_reg <= DATA_RESET;
         offset_act <= OFFSET_RESET;
         gain_act <= GAIN_RESET;
      end else if (wr_data) begin
         data_reg <= reg_wdata;
         offset_act <= offset_pend;
         gain_act <= gain_pend;
      end
   end

   // output code and readback
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         dac_code <= '0;
         reg_rdata <= '0;
         reg_rvalid <= 1'b0;
      end else begin
         dac_code <= next_code;
         reg_rvalid <= reg_read;
         if (reg_read) reg_rdata <= next_rdata;
      end
   end

   // measurement capture: code passed through with its linear encoding
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         meas_status <= '0;
         meas_is_temp <= 1'b0;
      end else begin
         meas_status <= meas_code;
         meas_is_temp <= meas_is_temp_in;
      end
   end

   // assertions
   property p_offset_hold;
      @(posedge ref_clk) disable iff (!arst_n)
      (wr_offset && !wr_data) |=> (offset_act == $past(offset_act));
   endproperty
   a_offset_hold: assert property (p_offset_hold) else $error("offset applied without data write");

   property p_gain_hold;
      @(posedge ref_clk) disable iff (!arst_n)
      (wr_gain && !wr_data) |=> (gain_act == $past(gain_act));
   endproperty
   a_gain_hold: assert property (p_gain_hold) else $error("gain applied without data write");

   property p_apply;
      @(posedge ref_clk) disable iff (!arst_n)
      wr_data |=> (offset_act == $past(offset_pend)) && (gain_act == $past(gain_pend));
   endproperty
   a_apply: assert property (p_apply) else $error("data write did not apply calibration");

   property p_read_offset;
      @(posedge ref_clk) disable iff (!arst_n)
      (reg_read && reg_addr == ADDR_OFFSET) |=> reg_rvalid && (reg_rdata == $past(offset_pend));
   endproperty
   a_read_offset: assert property (p_read_offset) else $error("offset readback wrong");

   property p_read_gain;
      @(posedge ref_clk) disable iff (!arst_n)
      (reg_read && reg_addr == ADDR_GAIN) |=> reg_rvalid && (reg_rdata == $past(gain_pend));
   endproperty
   a_read_gain: assert property (p_read_gain) else $error("gain readback wrong");

   property p_clamp_low;
      @(posedge ref_clk) disable iff (!arst_n)
      (wr_data && reg_wdata == '0 && offset_pend < OFFSET_RESET) ##1 !wr_data |=> (dac_code == '0);
   endproperty
   a_clamp_low: assert property (p_clamp_low) else $error("zero scale moved below bottom");

   property p_no_correction;
      @(posedge ref_clk) disable iff (!arst_n)
      (wr_data && offset_pend == OFFSET_RESET && gain_pend == GAIN_RESET) ##1 !wr_data
         |=> (dac_code == $past(data_reg, 1) - {15'h0000, ($past(data_reg, 1) != '0)});
   endproperty
   a_no_correction: assert property (p_no_correction) else $error("neutral calibration changed code");

   property p_meas;
      @(posedge ref_clk) disable iff (!arst_n)
      1'b1 |=> (meas_status == $past(meas_code)) && (meas_is_temp == $past(meas_is_temp_in));
   endproperty
   a_meas: assert property (p_meas) else $error("measurement code not reported");

   property p_status_read;
      @(posedge ref_clk) disable iff (!arst_n)
      (reg_read && reg_addr == ADDR_STATUS) |=> (reg_rdata[MEAS_W-1:0] == $past(meas_status));
   endproperty
   a_status_read: assert property (p_status_read) else $error("status word lacks measurement");

   // port, output path, status and calibration checks
   property p_rvalid_pulse;
      @(posedge ref_clk) disable iff (!arst_n)
      1'b1 |=> (reg_rvalid == $past(reg_read));
   endproperty
   a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read answer not one cycle after strobe");

   property p_rdata_hold;
      @(posedge ref_clk) disable iff (!arst_n)
      !reg_read |=> $stable(reg_rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without a read");

   property p_code_hold;
      @(posedge ref_clk) disable iff (!arst_n)
      !wr_data |-> ##2 $stable(dac_code);
   endproperty
   a_code_hold: assert property (p_code_hold) else $error("output code moved without data write");

   property p_clamp_any;
      @(posedge ref_clk) disable iff (!arst_n)
      sum_neg |=> (dac_code == '0);
   endproperty
   a_clamp_any: assert property (p_clamp_any) else $error("negative sum not held at zero scale");

   property p_status_bits;
      @(posedge ref_clk) disable iff (!arst_n)
      (reg_read && addr_is(reg_addr, ADDR_STATUS))
         |=> (reg_rdata[STAT_TEMP_BIT] == $past(meas_is_temp)) && (reg_rdata[WORD_W-1:STAT_TEMP_BIT+1] == '0);
   endproperty
   a_status_bits: assert property (p_status_bits) else $error("status word flag or spare bits wrong");

   property p_cal_untouched;
      @(posedge ref_clk) disable iff (!arst_n)
      (reg_write && !addr_is(reg_addr, ADDR_OFFSET) && !addr_is(reg_addr, ADDR_GAIN))
         |=> $stable(offset_pend) && $stable(gain_pend);
   endproperty
   a_cal_untouched: assert property (p_cal_untouched) else $error("other write disturbed calibration");

   // main scenarios
   c_offset_then_data: cover property (@(posedge ref_clk) disable iff (!arst_n) wr_offset ##[1:8] wr_data);
   c_gain_then_data: cover property (@(posedge ref_clk) disable iff (!arst_n) wr_gain ##[1:8] wr_data);
   c_clamped: cover property (@(posedge ref_clk) disable iff (!arst_n) sum_neg ##1 dac_code == '0);
   c_saturated: cover property (@(posedge ref_clk) disable iff (!arst_n) sum_over);
   c_neutral: cover property (@(posedge ref_clk) disable iff (!arst_n)
      wr_data && offset_pend == OFFSET_RESET && gain_pend == GAIN_RESET);

endmodule

`default_nettype wire

// [hw/cal_adjust_pkg.sv]
// Purpose: shared constants for the calibration adjust block
// Assumes: register port is the decoded serial host interface
// Notes: addresses are local indices of the decoded register port
package cal_adjust_pkg;
   // register port geometry
   localparam int ADDR_W = 3;
   localparam int WORD_W = 16;
   localparam int MEAS_W = 8;
   // register indices
   localparam logic [ADDR_W-1:0] ADDR_DATA = 3'h1;
   localparam logic [ADDR_W-1:0] ADDR_OFFSET = 3'h2;
   localparam logic [ADDR_W-1:0] ADDR_GAIN = 3'h3;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 3'h4;
   // reset values and neutral points
   localparam logic [WORD_W-1:0] OFFSET_RESET = 16'h8000;
   localparam logic [WORD_W-1:0] GAIN_RESET = 16'hFFFF;
   localparam logic [WORD_W-1:0] DATA_RESET = 16'h0000;
   localparam logic [WORD_W-1:0] CODE_MAX = 16'hFFFF;
   localparam logic [WORD_W+1:0] OFFSET_ZERO = 18'h08000;
   // status word layout
   localparam int STAT_MEAS_LSB = 0;
   localparam int STAT_TEMP_BIT = 8;
   // measurement encodings: volts = code * 2.5/256, degC = 312 - 1.559 * code
   localparam real MEAS_VOLT_FS = 2.5;
   localparam int MEAS_VOLT_DIV = 256;
   localparam real MEAS_TEMP_ZERO = 312.0;
   localparam real MEAS_TEMP_SLOPE = -1.559;
endpackage

// [verif/cal_host_model.sv]
// Purpose: host side of the register port
// Assumes: one strobe per access, answer one cycle later
// Notes: idle write data shows the inverse of the last word
`timescale 1ns/1ps
`default_nettype none
module cal_host_model
   import cal_adjust_pkg::*;
(
   input wire logic ref_clk,
   output logic reg_write,
   output logic reg_read,
   output logic [ADDR_W-1:0] reg_addr,
   output logic [WORD_W-1:0] reg_wdata,
   input wire logic [WORD_W-1:0] reg_rdata,
   input wire logic reg_rvalid
);
   // idle bus at time zero
   initial begin
      reg_write = 1'b0;
      reg_read = 1'b0;
      reg_addr = '0;
      reg_wdata = '0;
   end
   // one write strobe; cal writes are followed by a data write by the caller
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
      @(posedge ref_clk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_write = 1'b1;
      @(posedge ref_clk);
      #1;
      reg_write = 1'b0;
      reg_wdata = ~d;
   endtask
   // one read strobe, answer awaited a bounded count
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [WORD_W-1:0] d, output logic ok);
      @(posedge ref_clk);
      #1;
      reg_addr = a;
      reg_read = 1'b1;
      @(posedge ref_clk);
      #1;
      reg_read = 1'b0;
      ok = 1'b0;
      d = '0;
      for (int n = 0; n < 4 && !ok; n++) begin
         if (reg_rvalid === 1'b1) begin
            ok = 1'b1;
            d = reg_rdata;
         end else begin
            @(posedge ref_clk);
            #1;
         end
      end
   endtask
endmodule
`default_nettype wire

// [verif/dac_calibration_adjust_test.sv]
// Purpose: self-checking bench for the calibration path
// Assumes: host model drives the register port
// Notes: random words from a fixed-seed shift register
`timescale 1ns/1ps
`default_nettype none
module dac_calibration_adjust_test
   import cal_adjust_pkg::*;
;
   logic ref_clk = 1'b0, arst_n, reg_write, reg_read, reg_rvalid, meas_is_temp_in, meas_is_temp;
   logic [ADDR_W-1:0] reg_addr;
   logic [WORD_W-1:0] reg_wdata, reg_rdata, dac_code, o, g, d, prev;
   logic [MEAS_W-1:0] meas_code, meas_status;
   logic [31:0] seed = 32'h84DF;
   int err_total = 0;
   int checks_done = 0;
   cal_host_model host (.ref_clk(ref_clk), .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
   dac_calibration_adjust dut (.ref_clk(ref_clk), .arst_n(arst_n), .reg_write(reg_write), .reg_read(reg_read),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .meas_code(meas_code), .meas_is_temp_in(meas_is_temp_in), .meas_status(meas_status),
      .meas_is_temp(meas_is_temp), .dac_code(dac_code));
   // 200 MHz clock
   initial begin
      forever #2.5 ref_clk = ~ref_clk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // corrected code, clamped to the code range
   function automatic logic [WORD_W-1:0] exp_code(input logic [WORD_W-1:0] dv, gv, ov);
      longint v;
      v = ((longint'(dv) * longint'(gv)) >>> 16) + longint'(ov) - 32768;
      return (v < 0) ? 16'h0000 : (v > 65535) ? CODE_MAX : v[15:0];
   endfunction
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [WORD_W-1:0] e, input logic [WORD_W-1:0] s);
      checks_done++;
      if (s !== e) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, e, s);
      end
   endtask
   task automatic rchk(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] e, input string what);
      logic [WORD_W-1:0] v;
      logic ok;
      host.rd(a, v, ok);
      if (!ok) begin
         err_total++;
         tally_and_finish();
      end else begin
         chk(what, e, v);
      end
   endtask
   // reset, then random cal and data rounds with corner cases
   initial begin
      arst_n = 1'b0;
      meas_code = 8'h00;
      meas_is_temp_in = 1'b0;
      repeat (8) @(posedge ref_clk);
      #1;
      arst_n = 1'b1;
      rchk(ADDR_OFFSET, OFFSET_RESET, "offset reset");
      rchk(ADDR_GAIN, GAIN_RESET, "gain reset");
      chk("code reset", DATA_RESET, dac_code);
      for (int i = 0; i < 12; i++) begin
         seed = lfsr(lfsr(seed));
         o = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : (i == 2) ? OFFSET_RESET :
             (i == 3) ? {1'b0, seed[14:0]} : seed[15:0];
         g = (i == 1 || i == 2) ? GAIN_RESET : seed[31:16];
         d = (i == 0) ? 16'h0100 : (i == 1) ? 16'hFFFF : (i == 3) ? 16'h0000 : 16'(lfsr(seed) >> 9);
         prev = dac_code;
         host.wr(ADDR_OFFSET, o);
         host.wr(ADDR_GAIN, g);
         rchk(ADDR_OFFSET, o, "offset readback");
         rchk(ADDR_GAIN, g, "gain readback");
         chk("code before apply", prev, dac_code);
         host.wr(ADDR_DATA, d);
         @(posedge ref_clk);
         #1;
         chk("corrected code", exp_code(d, g, o), dac_code);
         rchk(ADDR_DATA, d, "data readback");
         meas_code = seed[23:16];
         meas_is_temp_in = seed[24];
         @(posedge ref_clk);
         #1;
         chk("measurement", {8'h00, seed[23:16]}, {8'h00, meas_status});
         chk("temperature flag", {15'h0000, seed[24]}, {15'h0000, meas_is_temp});
         host.wr(ADDR_STATUS, 16'hFFFF);
         rchk(ADDR_STATUS, {7'h00, seed[24], seed[23:16]}, "status word");
      end
      // mid-run reset puts calibration and output back to neutral
      @(posedge ref_clk);
      #1;
      arst_n = 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      arst_n = 1'b1;
      chk("code after reset", 16'h0000, dac_code);
      rchk(ADDR_OFFSET, OFFSET_RESET, "offset after reset");
      rchk(ADDR_GAIN, GAIN_RESET, "gain after reset");
      rchk(ADDR_DATA, DATA_RESET, "data after reset");
      rchk(3'h0, 16'h0000, "unmapped read");
      tally_and_finish();
   end
endmodule
`default_nettype wire
